// *** late_write_pkg.sv ***
// Purpose: Shared constants and the lane-sliced storage array of the late-write RAM port
// Assumes: One clock; the array needs no reset because its contents are undefined at power-up
// Notes:   A write lands one edge after the pending buffer fills; reads are combinational

`timescale 1ns/1ps

package late_write_pkg;
   // Organization of the two variants
   localparam int LANE_W       = 9;
   localparam int LANES_X36    = 4;
   localparam int LANES_X18    = 2;
   localparam int DEPTH_X36    = 131072;
   localparam int DEPTH_X18    = 262144;
   localparam int ADDR_W_X36   = 17;
   localparam int ADDR_W_X18   = 18;
   // Pipeline timing, in clock cycles after the command edge
   localparam int WRITE_DATA_DELAY = 1;
   localparam int READ_LATENCY     = 1;
   // Reset values of control state
   localparam logic RESET_DRIVE_N = 1'b1;
   localparam logic RESET_VALID   = 1'b0;
   localparam logic RESET_SLEEP   = 1'b0;
endpackage

module lane_array #(
   parameter int LANES  = late_write_pkg::LANES_X36,
   parameter int ADDR_W = late_write_pkg::ADDR_W_X36,
   parameter int DEPTH  = late_write_pkg::DEPTH_X36
) (
   input  wire logic                                      ref_clk,
   input  wire logic                                      write_en,
   input  wire logic [ADDR_W-1:0]                         write_addr,
   input  wire logic [LANES*late_write_pkg::LANE_W-1:0]   write_data,
   input  wire logic [LANES-1:0]                          write_lane_en,
   input  wire logic [ADDR_W-1:0]                         read_addr,
   output logic      [LANES*late_write_pkg::LANE_W-1:0]   read_data
);
   // One memory per byte lane so that each lane writes on its own enable
   for (genvar lane = 0; lane < LANES; lane++) begin : g_lane
      logic [late_write_pkg::LANE_W-1:0] mem [DEPTH];

      // Lane write; other lanes of the word keep their old contents
      always_ff @(posedge ref_clk) begin
         if (write_en && write_lane_en[lane]) begin // RULE6
            mem[write_addr] <= write_data[lane*late_write_pkg::LANE_W +: late_write_pkg::LANE_W];
         end
      end

      // Combinational read; the caller registers it
      assign read_data[lane*late_write_pkg::LANE_W +: late_write_pkg::LANE_W] = mem[read_addr];
   end
endmodule

// *** late_write_sram_port.sv ***
// Purpose: Device-side logic of a synchronous late-write static RAM bus
// Assumes: ref_clk is the true clock of the differential pair; bus inputs are synchronous to it
// Notes:   Output enable pin is not modelled; it has no function in this device
//
// Behaviour
// (RULE1) Address, write enables and chip select are captured each rising clock edge.
// (RULE2) Write data arrives one cycle after its command and is held pending.
// (RULE3) Read data is launched onto the data pins on a rising clock edge.
// (RULE4) Storage is 128K x 36 or 256K x 18, chosen by variant.
// (RULE5) Byte enables act only with the write strobe; reads ignore them.
// (RULE6) Write strobe is registered; a write updates every enabled byte lane.
// (RULE7) Chip select is registered; operations occur only when sampled low.
// (RULE8) The controller holds the output-enable input low permanently.
// (RULE9) Sleep input high puts the RAM to sleep; low is normal operation.
// (RULE10) The controller supplies the clock as a differential pair.
// (RULE11) The 36-bit variant has four nine-bit byte lanes, each with its enable.

`timescale 1ns/1ps

module late_write_sram_port #(
   parameter bit WIDE_VARIANT = 1'b1 // 1: 128K x 36, 0: 256K x 18
) (
   ref_clk,
   reset,
   registered_address,
   chip_select_n,
   write_strobe_n,
   byte_write_select_n,
   data_io_lanes_in,
   data_io_lanes_out,
   data_io_lanes_oe_n,
   sleep_request,
   sleep_active
);
   // Variant geometry
   localparam int LANES  = WIDE_VARIANT ? late_write_pkg::LANES_X36  : late_write_pkg::LANES_X18;
   localparam int ADDR_W = WIDE_VARIANT ? late_write_pkg::ADDR_W_X36 : late_write_pkg::ADDR_W_X18;
   localparam int DEPTH  = WIDE_VARIANT ? late_write_pkg::DEPTH_X36  : late_write_pkg::DEPTH_X18;
   localparam int DATA_W = LANES * late_write_pkg::LANE_W; // RULE4 RULE11

   input  wire logic              ref_clk;
   input  wire logic              reset;
   input  wire logic [ADDR_W-1:0] registered_address;
   input  wire logic              chip_select_n;
   input  wire logic              write_strobe_n;
   input  wire logic [LANES-1:0]  byte_write_select_n;
   input  wire logic [DATA_W-1:0] data_io_lanes_in;
   output logic      [DATA_W-1:0] data_io_lanes_out;
   output logic                   data_io_lanes_oe_n;
   input  wire logic              sleep_request;
   output logic                   sleep_active;

   // All port state in one word; the control fields and rd_data are reset, the other data fields need not be
   typedef struct packed {
      logic              sleep_meta;
      logic              sleep_sync;
      logic              cmd_rd;
      logic              cmd_wr;
      logic [ADDR_W-1:0] cmd_addr;
      logic [LANES-1:0]  cmd_be;
      logic              pend_valid;
      logic [ADDR_W-1:0] pend_addr;
      logic [DATA_W-1:0] pend_data;
      logic [LANES-1:0]  pend_be;
      logic [DATA_W-1:0] rd_data;
      logic              drive_n;
   } state_s;

   state_s            st;
   state_s            next_st;
   logic              accept;
   logic              fwd_hit;
   logic [DATA_W-1:0] mem_rd;
   logic [DATA_W-1:0] fwd_data;

   // Storage; written from the pending buffer one edge after data capture
   lane_array #(
      .LANES  (LANES),
      .ADDR_W (ADDR_W),
      .DEPTH  (DEPTH)
   ) u_array (
      .ref_clk       (ref_clk),
      .write_en      (st.pend_valid),
      .write_addr    (st.pend_addr),
      .write_data    (st.pend_data),
      .write_lane_en (st.pend_be),
      .read_addr     (st.cmd_addr),
      .read_data     (mem_rd)
   );

   // Read right behind a write to the same word must see the pending bytes
   assign fwd_hit = st.pend_valid && (st.pend_addr == st.cmd_addr);
   for (genvar lane = 0; lane < LANES; lane++) begin : g_fwd
      assign fwd_data[lane*late_write_pkg::LANE_W +: late_write_pkg::LANE_W] =
         (fwd_hit && st.pend_be[lane])
            ? st.pend_data[lane*late_write_pkg::LANE_W +: late_write_pkg::LANE_W]
            : mem_rd[lane*late_write_pkg::LANE_W +: late_write_pkg::LANE_W];
   end

   // Next-state logic for the whole port
   always_comb begin
      next_st = st;
      // Sleep pin is asynchronous to the bus, so two flops before use
      next_st.sleep_meta = sleep_request;
      next_st.sleep_sync = st.sleep_meta; // RULE9
      // Commands are ignored while asleep; contents are retained
      accept = !chip_select_n && !st.sleep_sync; // RULE7 RULE9
      next_st.cmd_rd   = accept && write_strobe_n; // RULE1
      next_st.cmd_wr   = accept && !write_strobe_n; // RULE1 RULE6
      next_st.cmd_addr = registered_address; // RULE1
      // Enables are dropped on reads so they cannot leak into the pending buffer
      next_st.cmd_be   = (accept && !write_strobe_n) ? ~byte_write_select_n : '0; // RULE5
      // Late write: data sampled one edge after the command
      next_st.pend_valid = st.cmd_wr; // RULE2
      if (st.cmd_wr) begin
         next_st.pend_addr = st.cmd_addr;
         next_st.pend_data = data_io_lanes_in; // RULE2
         next_st.pend_be   = st.cmd_be; // RULE6
      end
      // Read data launched at the edge after the command, driven one cycle
      next_st.drive_n = !st.cmd_rd; // RULE3
      if (st.cmd_rd) begin
         next_st.rd_data = fwd_data; // RULE3
      end
      if (reset) begin
         next_st.sleep_meta = late_write_pkg::RESET_SLEEP;
         next_st.sleep_sync = late_write_pkg::RESET_SLEEP;
         next_st.cmd_rd     = late_write_pkg::RESET_VALID;
         next_st.cmd_wr     = late_write_pkg::RESET_VALID;
         next_st.cmd_be     = '0;
         next_st.pend_valid = late_write_pkg::RESET_VALID;
         next_st.rd_data    = '0;
         next_st.drive_n    = late_write_pkg::RESET_DRIVE_N;
      end
   end

   // State register
   always_ff @(posedge ref_clk) begin
      st <= next_st;
   end

   // Outputs straight from flops
   assign data_io_lanes_out  = st.rd_data;
   assign data_io_lanes_oe_n = st.drive_n;
   assign sleep_active       = st.sleep_sync;

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   // Command shapes as the port accepts them
   sequence s_read_cmd;
      !chip_select_n && write_strobe_n && !st.sleep_sync;
   endsequence

   sequence s_write_cmd;
      !chip_select_n && !write_strobe_n && !st.sleep_sync;
   endsequence

   // Write command followed by the edge that takes its data
   sequence s_write_then_data;
      s_write_cmd ##1 1'b1;
   endsequence

   a_read_drive_timing: assert property (s_read_cmd |=> ##1 !data_io_lanes_oe_n) // RULE3
      else $error("Read data not driven two edges after read command");

   a_idle_no_drive: assert property (chip_select_n |=> ##1 data_io_lanes_oe_n) // RULE7
      else $error("Data pins driven without a selected read");

   a_write_addr_capture: assert property ( // RULE1
      s_write_cmd |=> ##1 (st.pend_valid && st.pend_addr == $past(registered_address, 2)))
      else $error("Pending write address differs from the command address");

   a_late_data_capture: assert property ( // RULE2
      s_write_cmd ##1 1'b1 |=> (st.pend_data == $past(data_io_lanes_in)))
      else $error("Write data not taken one cycle after the command");

   a_read_ignores_be: assert property (write_strobe_n |=> (st.cmd_be == '0)) // RULE5
      else $error("Byte enables captured on a read cycle");

   a_write_be_capture: assert property ( // RULE6
      s_write_cmd |=> (st.cmd_be == ~$past(byte_write_select_n)))
      else $error("Byte enables of a write not captured");

   a_sleep_blocks_cmds: assert property (st.sleep_sync |=> !st.cmd_rd && !st.cmd_wr) // RULE9
      else $error("Command accepted while asleep");

   a_sleep_entry: assert property ($rose(sleep_request) |=> ##1 sleep_active) // RULE9
      else $error("Sleep not entered two edges after request");

   // The pending buffer keeps the lanes chosen at the command edge, not later ones
   a_write_lane_keep: assert property ( // RULE6
      s_write_then_data |=> (st.pend_be == ~$past(byte_write_select_n, 2)))
      else $error("Pending write lanes differ from the command enables");

   // Every accepted write moves into the pending buffer on the next edge
   a_pend_from_cmd: assert property ( // RULE2
      st.cmd_wr |=> (st.pend_valid && st.pend_addr == $past(st.cmd_addr)))
      else $error("Accepted write did not move into the pending buffer");

   // Deselected cycles never leave a write pending
   a_deselect_no_write: assert property (chip_select_n |=> ##1 !st.pend_valid) // RULE7
      else $error("Write pending without a selected command");

   // A write command must never turn the data pins around
   a_write_no_drive: assert property (s_write_cmd |=> ##1 data_io_lanes_oe_n) // RULE3
      else $error("Data pins driven after a write command");

   // Pins are driven for one cycle per read, so a following write slot stays free
   a_drive_one_cycle: assert property ( // RULE3
      !data_io_lanes_oe_n && !st.cmd_rd |=> data_io_lanes_oe_n)
      else $error("Data pins driven longer than one cycle");

   // Read data stands still between reads so the controller may sample it late
   a_out_held: assert property (!st.cmd_rd |=> $stable(data_io_lanes_out)) // RULE3
      else $error("Read data changed without a read");

   // Leaving sleep takes the same two edges as entering it
   a_sleep_exit: assert property ($fell(sleep_request) |=> ##1 !sleep_active) // RULE9
      else $error("Sleep not left two edges after release");
endmodule

// *** sram_ctrl_model.sv ***
// Purpose: Controller model driving the late-write RAM bus
// Assumes: The bench calls issue once per cycle, idle included
// Notes:   Data pins carry write data only in the cycle after a write command
`timescale 1ns/1ps
module sram_ctrl_model (
   input  wire logic        ref_clk,
   output logic             ref_clk_n,
   output logic             output_enable_n,
   output logic [16:0]      registered_address,
   output logic             chip_select_n,
   output logic             write_strobe_n,
   output logic [3:0]       byte_write_select_n,
   output logic [35:0]      data_io_lanes_in,
   output logic             sleep_request
);
   logic [35:0] next_data = 36'h0_0000_0000;
   initial data_io_lanes_in = 36'h0_0000_0000;
   // Clock complement and the unused output enable held low
   assign ref_clk_n       = ~ref_clk;
   assign output_enable_n = 1'b0;
   // Outside a write-data cycle the pins toggle, so stale data cannot pass
   always @(negedge ref_clk) begin
      data_io_lanes_in <= (!chip_select_n && !write_strobe_n) ? next_data : ~data_io_lanes_in;
   end
   // One command per call, launched on the falling edge
   task automatic issue(input logic sl, input logic sel, input logic wr,
                        input logic [16:0] a, input logic [3:0] be, input logic [35:0] d);
      @(negedge ref_clk);
      sleep_request       <= sl;
      chip_select_n       <= ~sel;
      write_strobe_n      <= ~wr;
      registered_address  <= a;
      byte_write_select_n <= be;
      next_data           <= d;
   endtask
   initial begin
      sleep_request       = 1'b0;
      chip_select_n       = 1'b1;
      write_strobe_n      = 1'b1;
      registered_address  = 17'h0_0000;
      byte_write_select_n = 4'hf;
   end
endmodule

// *** late_write_sram_port_bench.sv ***
// Purpose: Self-checking bench of the late-write RAM port, wide variant
// Assumes: Reads target only words written earlier; array is not reset
// Notes:   Reads are checked two falling edges after issue
`timescale 1ns/1ps
module late_write_sram_port_bench;
   logic        ref_clk, reset, ref_clk_n, output_enable_n;
   logic [16:0] registered_address;
   logic        chip_select_n, write_strobe_n, sleep_request, sleep_active;
   logic [3:0]  byte_write_select_n;
   logic [35:0] data_io_lanes_in, data_io_lanes_out;
   logic        data_io_lanes_oe_n;
   int          mismatches = 0;
   int          comparisons = 0;
   logic [35:0] ref_mem [logic [16:0]];
   logic        pv [1:2] = '{default: 1'b0};
   logic [35:0] pd [1:2];
   logic [16:0] addrs [8] = '{17'h0_0000, 17'h1_ffff, 17'h0_0001, 17'h1_0000,
                              17'h0_5555, 17'h0_aaaa, 17'h1_fffe, 17'h0_0002};
   late_write_sram_port #(.WIDE_VARIANT(1'b1)) u_late_write_sram_port (
      .ref_clk(ref_clk), .reset(reset), .registered_address(registered_address),
      .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
      .byte_write_select_n(byte_write_select_n), .data_io_lanes_in(data_io_lanes_in),
      .data_io_lanes_out(data_io_lanes_out), .data_io_lanes_oe_n(data_io_lanes_oe_n),
      .sleep_request(sleep_request), .sleep_active(sleep_active));
   sram_ctrl_model u_sram_ctrl_model (
      .ref_clk(ref_clk), .ref_clk_n(ref_clk_n), .output_enable_n(output_enable_n),
      .registered_address(registered_address), .chip_select_n(chip_select_n),
      .write_strobe_n(write_strobe_n), .byte_write_select_n(byte_write_select_n),
      .data_io_lanes_in(data_io_lanes_in), .sleep_request(sleep_request));
   // Clock at 25 MHz
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // Merge enabled nine-bit lanes of a write into the old word
   function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] d,
                                         input logic [3:0] be);
      for (int i = 0; i < 4; i++) if (!be[i]) old[9*i +: 9] = d[9*i +: 9];
      return old;
   endfunction
   task automatic chk(input bit ok, input string msg);
      comparisons++;
      if (!ok) begin
         mismatches++;
         $display("MISMATCH at %0t: %s", $time, msg);
      end
   endtask
   // One bus cycle; live is low where sleep must drop the command
   task automatic step(input logic sl, input logic live, input logic sel, input logic wr,
                       input logic [16:0] a, input logic [3:0] be, input logic [35:0] d);
      u_sram_ctrl_model.issue(sl, sel, wr, a, be, d);
      if (pv[2]) begin
         chk(data_io_lanes_oe_n === 1'b0, "read not driven");
         chk(data_io_lanes_out === pd[2], "read data wrong");
      end else chk(data_io_lanes_oe_n === 1'b1, "pins driven without read");
      pv[2] = pv[1];
      pd[2] = pd[1];
      pv[1] = live && sel && !wr;
      if (live && sel && wr) ref_mem[a] = merge(ref_mem[a], d, be);
      pd[1] = pv[1] ? ref_mem[a] : 36'h0_0000_0000;
   endtask
   task automatic rnd(input logic sl, input logic live);
      step(sl, live, 1'(($urandom % 8) != 0), 1'($urandom), addrs[$urandom % 8],
           4'($urandom), 36'({$urandom, $urandom}));
   endtask
   task automatic stop_test;
      $display("counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Watchdog cuts a hang short
   initial begin
      repeat (2000) @(posedge ref_clk);
      mismatches++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      stop_test;
   end
   initial begin
      reset = 1'b1;
      void'($urandom(32'h8ac4_d2d8));
      repeat (16) @(negedge ref_clk);
      reset = 1'b0;
      chk(data_io_lanes_oe_n === 1'b1 && sleep_active === 1'b0, "reset state");
      foreach (addrs[i]) step(0, 1, 1, 1, addrs[i], 4'h0, 36'({$urandom, $urandom}));
      $display("test fill done");
      repeat (300) rnd(0, 1);
      $display("test traffic done");
      repeat (4) step(1, 1, 0, 0, addrs[0], 4'hf, 36'h0_0000_0000);
      chk(sleep_active === 1'b1, "sleep not entered");
      repeat (20) rnd(1, 0);
      repeat (4) step(0, 1, 0, 0, addrs[0], 4'hf, 36'h0_0000_0000);
      chk(sleep_active === 1'b0, "sleep not left");
      repeat (100) rnd(0, 1);
      repeat (3) step(0, 1, 0, 0, addrs[0], 4'hf, 36'h0_0000_0000);
      $display("test sleep done");
      stop_test;
   end
endmodule
